// ### rtl/ccr_pkg.sv
// Package: register map, field positions, reset values, timing for ccr
package ccr_pkg;
    // Word byte addresses
    localparam logic [4:0] CCR_CTRL_A1 = 5'h00;
    localparam logic [4:0] CCR_CTRL_B1 = 5'h04;
    localparam logic [4:0] CCR_CTRL_A2 = 5'h08;
    localparam logic [4:0] CCR_CTRL_B2 = 5'h0C;
    localparam logic [4:0] CCR_MIRROR = 5'h10;
    localparam logic [4:0] CCR_IRQ_STAT = 5'h14;
    localparam logic [4:0] CCR_IRQ_MASK = 5'h18;
    // Control A fields
    localparam int CCR_A_EN = 7;
    localparam int CCR_A_RES = 6;
    localparam int CCR_A_INV = 4;
    localparam int CCR_A_FLT = 3;
    localparam int CCR_A_SP = 2;
    localparam int CCR_A_HYS = 1;
    localparam int CCR_A_SYNC = 0;
    // Control B fields
    localparam int CCR_B_RISE = 7;
    localparam int CCR_B_FALL = 6;
    localparam int CCR_B_PLUS_LO = 3;
    localparam int CCR_B_MINUS_LO = 0;
    // Writable bits of control A, bit 5 and result bit excluded
    localparam logic [7:0] CCR_A_WMASK = 8'h9F;
    localparam logic [7:0] CCR_A_RST = 8'h04;
    localparam logic [7:0] CCR_B_RST = 8'h00;
    // Plus input select codes
    localparam logic [2:0] CCR_P_PIN = 3'h0;
    localparam logic [2:0] CCR_P_DAC = 3'h5;
    localparam logic [2:0] CCR_P_REF = 3'h6;
    localparam logic [2:0] CCR_P_GND = 3'h7;
    // Minus input select codes
    localparam logic [2:0] CCR_N_REF = 3'h6;
    localparam logic [2:0] CCR_N_GND = 3'h7;
    // Glitch filter hold time
    localparam int CCR_CLK_MHZ = 25;
    localparam int CCR_HOLD_NS = 20;
    localparam int CCR_HOLD_RAW = (CCR_HOLD_NS * CCR_CLK_MHZ + 999) / 1000;
    localparam int CCR_HOLD_CYC = (CCR_HOLD_RAW < 1) ? 1 : CCR_HOLD_RAW;
endpackage : ccr_pkg

// ### rtl/ccr_comparator_regs.sv
// Control and status registers for two analog comparators, Wishbone slave
// Summary of operation
// - Bit 7 of control A switches each comparator on; off means no power.
// - Read-only result bit 6 is one when plus node exceeds minus node.
// - Polarity bit 4 inverts the result for register and outputs.
// - Filter bit 3 routes the result through the glitch filter, else bypass.
// - Speed bit 2 selects fast normal power at one, its reset value.
// - Hysteresis bit 1 turns on the comparator input hysteresis.
// - Sync bit 0 updates timer and pin output on timer clock falling edge.
// - Rise enable bit 7 of control B flags each rising result edge.
// - Fall enable bit 6 of control B flags each falling result edge.
// - Plus select bits 5:3 choose pin, DAC, reference, ground or float.
// - Minus select bits 2:0 choose minus pins, reference, ground or float.
// - Mirror register bits 0 and 1 copy the two result bits.
// - Unimplemented bits read zero and ignore writes.
// - All resets clear controls except speed bit, which resets to one.
// - Software clears the event flag; a new edge during clearing wins.
// - Edges are generated also while disabled, by polarity or enable toggles.
// - Filter blocks reversing a change for the hold interval.
module ccr_comparator_regs
    import ccr_pkg::*;
#(
    parameter int HOLD_CYC = CCR_HOLD_CYC
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Analog core raw decisions: plus node above minus node
    input wire logic [1:0] cmp_raw_i,
    // Timer clock source, sampled synchronously
    input wire logic timer_clk_i,
    // Analog core controls, index per comparator
    output logic [1:0] cmp_enable_o,
    output logic [1:0] speed_power_o,
    output logic [1:0] hysteresis_o,
    output logic [2:0] plus_sel1_o,
    output logic [2:0] plus_sel2_o,
    output logic [2:0] minus_sel1_o,
    output logic [2:0] minus_sel2_o,
    output logic [1:0] plus_float_o,
    output logic [1:0] minus_float_o,
    // Outputs to timer gate and pin
    output logic [1:0] cmp_out_o,
    // Event flags and interrupt
    output logic [1:0] cmp_event_flag_o,
    output logic irq_o
);
    function automatic logic plus_floats(input logic [2:0] c);
        plus_floats = !(c == CCR_P_PIN || c == CCR_P_DAC ||
                        c == CCR_P_REF || c == CCR_P_GND);
    endfunction : plus_floats

    function automatic logic minus_floats(input logic [2:0] c);
        minus_floats = !(c[2] == 1'b0 || c == CCR_N_REF || c == CCR_N_GND);
    endfunction : minus_floats

    logic [7:0] ctla_r [2];
    logic [7:0] ctlb_r [2];
    logic [1:0] filt_r;
    logic [1:0] prev_r;
    logic [1:0] stat_r;
    logic [1:0] mask_r;
    logic tclk_r;
    logic [7:0] hold_r [2];
    wire logic [1:0] res;
    wire logic [1:0] pol;
    wire logic [1:0] rise;
    wire logic [1:0] fall;
    wire logic [1:0] evt;

    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr = req && wb_we_i && wb_sel_i[0];
    wire tfall = tclk_r && !timer_clk_i;
    wire [7:0] wlane = wb_dat_i[7:0];
    wire clr_hit = wr && wb_adr_i == CCR_IRQ_STAT;
    // Set wins: events are ORed in after the clear
    wire [1:0] stat_nxt = (stat_r & ~(clr_hit ? wlane[1:0] : 2'h0)) | evt;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_cmp
            assign pol[g] = ctla_r[g][CCR_A_INV];
            // disabled core reads low, polarity still applies
            wire raw = ctla_r[g][CCR_A_EN] & cmp_raw_i[g];
            assign res[g] = ctla_r[g][CCR_A_FLT] ? filt_r[g] : (raw ^ pol[g]);
            assign rise[g] = res[g] & ~prev_r[g];
            assign fall[g] = ~res[g] & prev_r[g];
            assign evt[g] = (rise[g] & ctlb_r[g][CCR_B_RISE]) |
                            (fall[g] & ctlb_r[g][CCR_B_FALL]);
        end
    endgenerate

    wire [7:0] rd_a1 = (ctla_r[0] & CCR_A_WMASK) | {1'b0, res[0], 6'h00};
    wire [7:0] rd_a2 = (ctla_r[1] & CCR_A_WMASK) | {1'b0, res[1], 6'h00};
    wire [7:0] rd_mir = {6'h00, res};
    logic [7:0] rd_sel;
    always_comb begin
        case (wb_adr_i)
            CCR_CTRL_A1: rd_sel = rd_a1;
            CCR_CTRL_B1: rd_sel = ctlb_r[0];
            CCR_CTRL_A2: rd_sel = rd_a2;
            CCR_CTRL_B2: rd_sel = ctlb_r[1];
            CCR_MIRROR: rd_sel = rd_mir;
            CCR_IRQ_STAT: rd_sel = {6'h00, stat_r};
            CCR_IRQ_MASK: rd_sel = {6'h00, mask_r};
            default: rd_sel = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctla_r <= '{CCR_A_RST, CCR_A_RST};
            ctlb_r <= '{CCR_B_RST, CCR_B_RST};
            mask_r <= 2'h0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= req;
            wb_dat_o <= {24'h00_0000, rd_sel};
            if (wr) begin
                // bit 5 and result not writable
                case (wb_adr_i)
                    CCR_CTRL_A1: ctla_r[0] <= wlane & CCR_A_WMASK;
                    CCR_CTRL_B1: ctlb_r[0] <= wlane;
                    CCR_CTRL_A2: ctla_r[1] <= wlane & CCR_A_WMASK;
                    CCR_CTRL_B2: ctlb_r[1] <= wlane;
                    CCR_IRQ_MASK: mask_r <= wlane[1:0];
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_r <= 2'h0;
            cmp_event_flag_o <= 2'h0;
            irq_o <= 1'b0;
        end else if (ce_i) begin
            stat_r <= stat_nxt;
            // Flag and interrupt move in the same cycle as status
            cmp_event_flag_o <= stat_nxt;
            irq_o <= |(stat_nxt & mask_r);
        end
    end

    // hold filter: an accepted change freezes output for HOLD_CYC
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            filt_r <= 2'h0;
            hold_r <= '{8'h00, 8'h00};
            prev_r <= 2'h0;
        end else if (ce_i) begin
            prev_r <= res;
            for (int i = 0; i < 2; i++) begin
                if (hold_r[i] != 8'h00) begin
                    hold_r[i] <= hold_r[i] - 8'h01;
                end else if (filt_r[i] !=
                             ((ctla_r[i][CCR_A_EN] & cmp_raw_i[i]) ^ pol[i]))
                begin
                    filt_r[i] <= ~filt_r[i];
                    hold_r[i] <= 8'(HOLD_CYC);
                end
            end
        end
    end

    // sync output on timer clock falling edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tclk_r <= 1'b0;
            cmp_out_o <= 2'h0;
        end else if (ce_i) begin
            tclk_r <= timer_clk_i;
            // Sync mode holds the last output until the timer clock falls
            for (int i = 0; i < 2; i++) begin
                cmp_out_o[i] <= ctla_r[i][CCR_A_SYNC] ?
                    (tfall ? res[i] : cmp_out_o[i]) : res[i];
            end
        end
    end

    // Analog controls registered for clean outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_enable_o <= 2'h0;
            speed_power_o <= 2'h3;
            hysteresis_o <= 2'h0;
            plus_sel1_o <= 3'h0;
            plus_sel2_o <= 3'h0;
            minus_sel1_o <= 3'h0;
            minus_sel2_o <= 3'h0;
            plus_float_o <= 2'h0;
            minus_float_o <= 2'h0;
        end else if (ce_i) begin
            for (int i = 0; i < 2; i++) begin
                cmp_enable_o[i] <= ctla_r[i][CCR_A_EN];
                speed_power_o[i] <= ctla_r[i][CCR_A_SP];
                hysteresis_o[i] <= ctla_r[i][CCR_A_HYS];
                plus_float_o[i] <= plus_floats(ctlb_r[i][5:3]);
                minus_float_o[i] <= minus_floats(ctlb_r[i][2:0]);
            end
            plus_sel1_o <= ctlb_r[0][5:3];
            plus_sel2_o <= ctlb_r[1][5:3];
            minus_sel1_o <= ctlb_r[0][2:0];
            minus_sel2_o <= ctlb_r[1][2:0];
        end
    end
endmodule : ccr_comparator_regs

// ### sim/ccr_checker.sv
// Concurrent checks on the comparator register bank ports
module ccr_checker
    import ccr_pkg::*;
#(
    parameter int HOLD_CYC = 1
) (
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Controls and events
    input wire logic [1:0] cmp_enable_o,
    input wire logic [1:0] speed_power_o,
    input wire logic [2:0] plus_sel1_o,
    input wire logic [2:0] minus_sel1_o,
    input wire logic [1:0] plus_float_o,
    input wire logic [1:0] minus_float_o,
    input wire logic [1:0] cmp_event_flag_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    endsequence
    sequence s_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_answer: assert property (s_req |=> s_answer)
        else $error("request not answered by one ack pulse");
    a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    a_irq_cause: assert property (irq_o |->
        ($past(|cmp_event_flag_o) || |cmp_event_flag_o))
        else $error("interrupt without event flag");
    // Flag 0 only drops one or two cycles after a status write
    a_flag_clear: assert property ($fell(cmp_event_flag_o[0]) |->
        $past(wb_we_i && wb_adr_i == CCR_IRQ_STAT) ||
        $past(wb_we_i && wb_adr_i == CCR_IRQ_STAT, 2))
        else $error("event flag dropped without clear");
    a_enable_write: assert property ($changed(cmp_enable_o) |->
        $past(wb_cyc_i && wb_we_i) || $past(wb_cyc_i && wb_we_i, 2))
        else $error("enable changed without write");
    a_speed_write: assert property ($changed(speed_power_o) |->
        $past(wb_cyc_i && wb_we_i) || $past(wb_cyc_i && wb_we_i, 2))
        else $error("speed changed without write");
    a_plus_float: assert property (plus_float_o[0] ==
        (plus_sel1_o inside {[3'h1:3'h4]}))
        else $error("plus float decode wrong");
    a_minus_float: assert property (minus_float_o[0] ==
        (minus_sel1_o inside {3'h4, 3'h5}))
        else $error("minus float decode wrong");
endmodule : ccr_checker

// ### sim/ccr_core_model.sv
// Behavioural analog comparator cores and timer clock source
module ccr_core_model (
    // Controls from the bank and bench stimulus
    input wire logic clk_i,
    input wire logic [1:0] enable_i,
    input wire logic [1:0] plus_high_i,
    input wire logic run_i,
    // Raw decisions and timer clock
    output logic [1:0] raw_o,
    output logic tclk_o
);
    logic [1:0] div_r;
    assign raw_o = enable_i & plus_high_i;
    // Timer clock stands low while stopped
    always_ff @(posedge clk_i) begin
        if (!run_i) begin
            div_r <= 2'h0;
        end else begin
            div_r <= div_r + 2'h1;
        end
    end
    assign tclk_o = div_r[1];
endmodule : ccr_core_model

// ### sim/ccr_comparator_regs_bench.sv
// Self-checking bench for the comparator register bank
`define CK(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module ccr_comparator_regs_bench import ccr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [4:0] a; logic [3:0] s; logic [7:0] d, x;} ccr_row_t;
    logic clk_i = 0, rst_i = 1, ce_i = 1, cyc = 0, stb = 0, we = 0;
    logic [4:0] adr = 5'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000, dato, rd;
    logic ack, irq, tclk, run = 0;
    logic [1:0] lvl = 2'h0, raw, en, sp, pf, mf, out, flg;
    int n_errors = 0, n_compared = 0;
    ccr_row_t rows[9] = '{'{CCR_CTRL_A1, 4'h1, 8'hFF, 8'hDF},
        '{CCR_CTRL_A1, 4'h0, 8'h00, 8'hDF}, '{CCR_CTRL_A1, 4'h1, 8'h00, 8'h00},
        '{CCR_CTRL_B1, 4'h1, 8'hFF, 8'hFF}, '{CCR_CTRL_B1, 4'h1, 8'h24, 8'h24},
        '{CCR_CTRL_A2, 4'h1, 8'h1E, 8'h5E}, '{CCR_MIRROR, 4'h1, 8'hFF, 8'h02},
        '{5'h1C, 4'h1, 8'hFF, 8'h00}, '{CCR_CTRL_A2, 4'h1, 8'h04, 8'h04}};
    always #20 clk_i = ~clk_i;
    ccr_comparator_regs #(.HOLD_CYC(1)) ccr_comparator_regs_i (
        .clk_i, .rst_i, .ce_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dato), .wb_ack_o(ack), .cmp_raw_i(raw),
        .timer_clk_i(tclk), .cmp_enable_o(en), .speed_power_o(sp),
        .hysteresis_o(), .plus_sel1_o(), .plus_sel2_o(),
        .minus_sel1_o(), .minus_sel2_o(), .plus_float_o(pf),
        .minus_float_o(mf), .cmp_out_o(out), .cmp_event_flag_o(flg),
        .irq_o(irq));
    ccr_core_model ccr_core_model_i (.clk_i, .enable_i(en),
        .plus_high_i(lvl), .run_i(run), .raw_o(raw), .tclk_o(tclk));
    task close_out();
        if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : close_out
    task wt();
        repeat (4) @(posedge clk_i);
    endtask : wt
    // Classic cycle, held until ack is sampled high
    task wb(input logic [4:0] a, input logic [3:0] s, input logic w,
            input logic [31:0] d);
        int k;
        @(posedge clk_i);
        {cyc, stb, we, adr, sel, dat} <= {1'b1, 1'b1, w, a, s, d};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 16);
        if (ack !== 1'b1) begin
            n_errors++;
            close_out();
        end
        rd = dato;
        {cyc, stb} <= 2'b00;
    endtask : wb
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 0;
        `CK("speed", 2'h3, sp)
        wb(CCR_CTRL_A1, 4'h1, 0, 0);
        `CK("ctrl_a1", 32'h0000_0004, rd)
        wb(CCR_CTRL_B2, 4'h1, 0, 0);
        `CK("ctrl_b2", 32'h0000_0000, rd)
        foreach (rows[i]) begin
            wb(rows[i].a, rows[i].s, 1, {24'h00_0000, rows[i].d});
            wb(rows[i].a, 4'h1, 0, 0);
            `CK("row", {24'h00_0000, rows[i].x}, rd)
        end
        `CK("float", 4'h5, {pf, mf})
        `CK("speed_en", 4'h8, {sp, en})
        wb(CCR_IRQ_MASK, 4'h1, 1, 1);
        wb(CCR_CTRL_B1, 4'h1, 1, 32'h0000_0080);
        wb(CCR_CTRL_A1, 4'h1, 1, 32'h0000_0080);
        lvl <= 2'h1;
        wt();
        `CK("rise", 2'h3, {flg[0], irq})
        wb(CCR_IRQ_STAT, 4'h1, 0, 0);
        `CK("status", 32'h0000_0001, rd)
        wb(CCR_CTRL_A1, 4'h1, 0, 0);
        `CK("result", 32'h0000_00C0, rd)
        wb(CCR_IRQ_STAT, 4'h1, 1, 1);
        wt();
        `CK("clear", 2'h0, {flg[0], irq})
        lvl <= 2'h0;
        wt();
        `CK("fall_off", 1'b0, flg[0])
        wb(CCR_CTRL_B1, 4'h1, 1, 32'h0000_0040);
        lvl <= 2'h1;
        wt();
        `CK("rise_off", 1'b0, flg[0])
        lvl <= 2'h0;
        wt();
        `CK("fall", 2'h3, {flg[0], irq})
        wb(CCR_IRQ_MASK, 4'h1, 1, 0);
        wt();
        `CK("masked", 2'h2, {flg[0], irq})
        wb(CCR_IRQ_STAT, 4'h1, 1, 1);
        wb(CCR_CTRL_B1, 4'h1, 1, 32'h0000_0080);
        wb(CCR_CTRL_A1, 4'h1, 1, 32'h0000_0010);
        wt();
        `CK("off_edge", 1'b1, flg[0])
        wb(CCR_CTRL_A1, 4'h1, 1, 32'h0000_0081);
        wt();
        `CK("sync_hold", 1'b1, out[0])
        run <= 1;
        repeat (3) wt();
        `CK("sync_move", 1'b0, out[0])
        ce_i <= 0;
        lvl <= 2'h1;
        repeat (3) wt();
        `CK("frozen", 1'b0, out[0])
        ce_i <= 1;
        repeat (3) wt();
        `CK("thawed", 1'b1, out[0])
        close_out();
    end
endmodule : ccr_comparator_regs_bench
bind ccr_comparator_regs ccr_checker #(.HOLD_CYC(HOLD_CYC)) ccr_checker_i (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cmp_enable_o(cmp_enable_o), .speed_power_o(speed_power_o),
    .plus_sel1_o(plus_sel1_o), .minus_sel1_o(minus_sel1_o),
    .plus_float_o(plus_float_o), .minus_float_o(minus_float_o),
    .cmp_event_flag_o(cmp_event_flag_o), .irq_o(irq_o));
